// ==== sffp_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
module sffp_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clear,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [PW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = count_reg != (PW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (clear) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // sffp_buf
`default_nettype wire

// ==== sffp_front.sv ====
// What this block does
// (RULE1) Addressed frame: opcode, then reserved bit, 13 page bits, 10 byte bits.
// (RULE2) D2h four dummy bytes; D4h/D6h one; D1h/D3h none; D7h no address.
// (RULE3) Clock mode 3 is the default after reset.
// (RULE4) Serial output stays high impedance after reset until a command drives it.
// (RULE5) Only a select falling edge after reset starts a valid instruction.
// (RULE6) Each select fall picks mode 0 or 3 from the idle clock level.
// (RULE7) Host waits 85 us after supply good before selecting the device.
// (RULE8) While reset is active every command is ignored.
// (RULE9) After reset release the block sits in standby, ready for a command.
// (RULE10) First program or erase waits up to 3 ms after power-up.
// (RULE11) Input bits captured on rising clock, output bits shifted on falling.
// (RULE12) Everything is most significant bit first; dummy values ignored.
`timescale 1ns/1ps
`default_nettype none
module sffp_front #(
	parameter int PE_DELAY_CYC = sffp_pkg::PE_DELAY_CYC
) (
	// System clock and power-on reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// Serial link
	input  wire logic        SCK,
	input  wire logic        CS_N,
	input  wire logic        SI,
	output logic             SO_OUT,
	output logic             SO_OE_N,
	// Interface status
	output logic             MODE3,
	output logic             STANDBY,
	output logic             PE_READY,
	output logic             OVERRUN,
	// Decoded command
	output logic             CMD_VALID,
	output logic [7:0]       CMD_OPCODE,
	output logic [12:0]      CMD_PAGE,
	output logic [9:0]       CMD_BYTE,
	// Payload bytes after the header
	output logic             DATA_VALID,
	output logic [7:0]       DATA_OUT,
	input  wire logic        DATA_READY,
	// Reply byte for the serial output
	input  wire logic [7:0]  TX_BYTE,
	input  wire logic        TX_DRIVE
);
	// ==========================================================
	// Link domain: capture on rising clock
	logic       link_rst;
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;
	logic [7:0] rx_byte_reg;
	logic       rx_tgl_reg;

	// Deselect ends the frame without needing a further clock edge
	assign link_rst = RESET | CS_N;

	always_ff @(posedge SCK or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_reg <= '0;
			shift_reg   <= '0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg   <= {shift_reg[5:0], SI}; // RULE11 RULE12
		end
	end

	// Toggle is not reset by deselect, so it never fakes an event
	always_ff @(posedge SCK or posedge RESET) begin
		if (RESET) begin
			rx_byte_reg <= '0;
			rx_tgl_reg  <= 1'b0;
		end else if (!CS_N && bit_cnt_reg == sffp_pkg::BIT_LAST_IDX) begin
			rx_byte_reg <= {shift_reg, SI}; // RULE12
			rx_tgl_reg  <= ~rx_tgl_reg;
		end
	end

	// ==========================================================
	// Link domain: shift out on falling clock
	logic       drv_s1_reg;
	logic       drv_s2_reg;
	logic [2:0] out_cnt_reg;
	logic [7:0] tx_hold_reg;
	logic       tx_drive_reg;

	always_ff @(negedge SCK or posedge link_rst) begin
		if (link_rst) begin
			drv_s1_reg  <= 1'b0;
			drv_s2_reg  <= 1'b0;
			out_cnt_reg <= '0;
			SO_OUT      <= 1'b0;
			SO_OE_N     <= 1'b1; // RULE4
		end else begin
			drv_s1_reg  <= tx_drive_reg;
			drv_s2_reg  <= drv_s1_reg;
			SO_OE_N     <= ~drv_s2_reg; // RULE4
			out_cnt_reg <= drv_s2_reg ? out_cnt_reg + 3'h1 : '0;
			SO_OUT      <= drv_s2_reg ? tx_hold_reg[3'h7 - out_cnt_reg] : 1'b0; // RULE11 RULE12
		end
	end

	// ==========================================================
	// System domain: synchronisers
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_prev_reg;
	logic sck_s1_reg;
	logic sck_s2_reg;
	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_prev_reg;
	logic cs_fall;
	logic byte_evt;

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			// Held at the selected level so a select low through reset shows no fall
			cs_s1_reg    <= ~sffp_pkg::CS_N_RESET;
			cs_s2_reg    <= ~sffp_pkg::CS_N_RESET;
			cs_prev_reg  <= ~sffp_pkg::CS_N_RESET;
			sck_s1_reg   <= 1'b0;
			sck_s2_reg   <= 1'b0;
			tgl_s1_reg   <= 1'b0;
			tgl_s2_reg   <= 1'b0;
			tgl_prev_reg <= 1'b0;
		end else begin
			cs_s1_reg    <= CS_N;
			cs_s2_reg    <= cs_s1_reg;
			cs_prev_reg  <= cs_s2_reg;
			sck_s1_reg   <= SCK;
			sck_s2_reg   <= sck_s1_reg;
			tgl_s1_reg   <= rx_tgl_reg;
			tgl_s2_reg   <= tgl_s1_reg;
			tgl_prev_reg <= tgl_s2_reg;
		end
	end

	assign cs_fall  = cs_prev_reg && !cs_s2_reg;
	assign byte_evt = tgl_s2_reg ^ tgl_prev_reg;

	// ==========================================================
	// Frame gating, mode pick, standby, power-up delay
	logic        frame_ok_reg;
	logic [31:0] pe_cnt_reg;

	// A frame already open at reset release is never armed
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			frame_ok_reg <= 1'b0; // RULE8
		else if (cs_fall)
			frame_ok_reg <= 1'b1; // RULE5
		else if (cs_s2_reg)
			frame_ok_reg <= 1'b0;
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			MODE3 <= sffp_pkg::MODE3_RESET; // RULE3
		else if (cs_fall)
			MODE3 <= sck_s2_reg; // RULE6
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			STANDBY <= 1'b0;
		else
			STANDBY <= ~frame_ok_reg; // RULE9
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pe_cnt_reg <= '0;
			PE_READY   <= 1'b0;
		end else if (pe_cnt_reg != 32'(PE_DELAY_CYC)) begin
			pe_cnt_reg <= pe_cnt_reg + 32'h1; // RULE10
		end else begin
			PE_READY   <= 1'b1; // RULE10
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_hold_reg  <= '0;
			tx_drive_reg <= 1'b0;
		end else begin
			tx_hold_reg  <= TX_BYTE;
			tx_drive_reg <= TX_DRIVE && frame_ok_reg; // RULE4
		end
	end

	// ==========================================================
	// Byte buffer between link and parser
	logic       buf_in_valid;
	logic       buf_in_ready;
	logic       buf_out_valid;
	logic [7:0] buf_out_data;
	logic       buf_out_ready;

	assign buf_in_valid = byte_evt && frame_ok_reg; // RULE5 RULE8

	sffp_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
		.clk       (CLK),
		.reset     (RESET),
		.clear     (~frame_ok_reg),
		.in_valid  (buf_in_valid),
		.in_data   (rx_byte_reg),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_data  (buf_out_data),
		.out_ready (buf_out_ready)
	);

	// The serial host cannot be stalled, so a lost byte is only flagged
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET)
			OVERRUN <= 1'b0;
		else if (buf_in_valid && !buf_in_ready)
			OVERRUN <= 1'b1;
		else if (cs_fall)
			OVERRUN <= 1'b0;
	end

	// ==========================================================
	// Header parser
	sffp_pkg::sffp_state_t state_reg;
	logic [1:0]  addr_cnt_reg;
	logic [2:0]  dummy_cnt_reg;
	logic [23:0] addr_reg;
	logic [23:0] addr_next;
	logic [23:0] addr_src;
	logic        pop;
	logic        emit;
	logic [2:0]  dummy_next;

	assign buf_out_ready = (state_reg != sffp_pkg::ST_DATA) || !DATA_VALID || DATA_READY;
	assign pop        = buf_out_valid && buf_out_ready;
	assign addr_next  = {addr_reg[15:0], buf_out_data};
	assign addr_src   = (state_reg == sffp_pkg::ST_ADDR) ? addr_next : addr_reg;
	assign dummy_next = sffp_pkg::dummy_count(CMD_OPCODE);

	always_comb begin
		emit = 1'b0;
		if (pop && frame_ok_reg) begin
			unique case (state_reg)
				sffp_pkg::ST_OPC:   emit = buf_out_data == sffp_pkg::OPC_STATUS;
				sffp_pkg::ST_ADDR:  emit = addr_cnt_reg == sffp_pkg::ADDR_LAST_IDX
					&& dummy_next == sffp_pkg::DUMMY_NONE;
				sffp_pkg::ST_DUMMY: emit = dummy_cnt_reg == 3'h1;
				sffp_pkg::ST_DATA:  emit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_reg     <= sffp_pkg::ST_OPC;
			addr_cnt_reg  <= '0;
			dummy_cnt_reg <= '0;
			addr_reg      <= '0;
			CMD_OPCODE    <= '0;
		end else if (!frame_ok_reg) begin
			state_reg     <= sffp_pkg::ST_OPC;
		end else if (pop) begin
			unique case (state_reg)
				sffp_pkg::ST_OPC: begin
					CMD_OPCODE   <= buf_out_data;
					addr_cnt_reg <= '0;
					// Status read has no address field
					state_reg    <= emit ? sffp_pkg::ST_DATA : sffp_pkg::ST_ADDR; // RULE2
				end
				sffp_pkg::ST_ADDR: begin
					addr_reg     <= addr_next; // RULE1 RULE12
					addr_cnt_reg <= addr_cnt_reg + 2'h1;
					if (addr_cnt_reg == sffp_pkg::ADDR_LAST_IDX) begin
						dummy_cnt_reg <= dummy_next; // RULE2
						state_reg     <= emit ? sffp_pkg::ST_DATA : sffp_pkg::ST_DUMMY;
					end
				end
				sffp_pkg::ST_DUMMY: begin
					// Dummy byte values are discarded
					dummy_cnt_reg <= dummy_cnt_reg - 3'h1; // RULE2 RULE12
					if (emit)
						state_reg <= sffp_pkg::ST_DATA;
				end
				sffp_pkg::ST_DATA: state_reg <= sffp_pkg::ST_DATA;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			CMD_VALID <= 1'b0;
			CMD_PAGE  <= '0;
			CMD_BYTE  <= '0;
		end else begin
			CMD_VALID <= emit;
			if (emit) begin
				// Page bits are dummy for buffer-only opcodes
				CMD_PAGE <= sffp_pkg::page_is_dummy(CMD_OPCODE) ? '0
					: addr_src[sffp_pkg::PAGE_MSB:sffp_pkg::PAGE_LSB]; // RULE1 RULE2
				CMD_BYTE <= addr_src[sffp_pkg::BYTE_MSB:0]; // RULE1
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			DATA_VALID <= 1'b0;
			DATA_OUT   <= '0;
		end else if (pop && state_reg == sffp_pkg::ST_DATA) begin
			DATA_VALID <= 1'b1;
			DATA_OUT   <= buf_out_data;
		end else if (DATA_READY) begin
			DATA_VALID <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_mode_default;
		$fell(RESET) |-> MODE3;
	endproperty
	a_mode_default: assert property (p_mode_default) else $error("mode not 3 after reset"); // RULE3

	property p_so_idle;
		cs_s2_reg && cs_prev_reg |-> SO_OE_N;
	endproperty
	a_so_idle: assert property (p_so_idle) else $error("output driven while deselected"); // RULE4

	property p_no_byte_unarmed;
		!frame_ok_reg |-> !buf_in_valid;
	endproperty
	a_no_byte_unarmed: assert property (p_no_byte_unarmed) else $error("byte taken unarmed"); // RULE5

	property p_mode_pick;
		cs_fall |=> MODE3 == $past(sck_s2_reg);
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from idle clock"); // RULE6

	property p_standby;
		!frame_ok_reg ##1 !frame_ok_reg |-> STANDBY;
	endproperty
	a_standby: assert property (p_standby) else $error("not in standby when idle"); // RULE9

	property p_pe_wait;
		$rose(PE_READY) |-> pe_cnt_reg == 32'(PE_DELAY_CYC);
	endproperty
	a_pe_wait: assert property (p_pe_wait) else $error("program delay count wrong"); // RULE10

	property p_dummy_four;
		pop && state_reg == sffp_pkg::ST_ADDR && addr_cnt_reg == sffp_pkg::ADDR_LAST_IDX
			&& CMD_OPCODE == sffp_pkg::OPC_PAGE_READ |=> dummy_cnt_reg == 3'h4;
	endproperty
	a_dummy_four: assert property (p_dummy_four) else $error("page read dummy count"); // RULE2

	property p_buf_page;
		CMD_VALID && sffp_pkg::page_is_dummy(CMD_OPCODE) |-> CMD_PAGE == '0;
	endproperty
	a_buf_page: assert property (p_buf_page) else $error("buffer opcode page not masked"); // RULE1

	property p_data_hold;
		DATA_VALID && !DATA_READY |=> DATA_VALID && $stable(DATA_OUT);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("payload dropped under stall"); // RULE12

	c_page_read: cover property (CMD_VALID && CMD_OPCODE == sffp_pkg::OPC_PAGE_READ);
	c_status:    cover property (CMD_VALID && CMD_OPCODE == sffp_pkg::OPC_STATUS);
	c_mode0:     cover property (cs_fall ##1 !MODE3);
	c_stall:     cover property (DATA_VALID && !DATA_READY [*3]);
endmodule // sffp_front
`default_nettype wire

// ==== sffp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sffp_host (
	// Serial link
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	localparam realtime HALF = 62.5;
	logic idle_hi;

	initial begin
		sck = 1'b1;
		cs_n = 1'b1;
		si = 1'b0;
		idle_hi = 1'b1;
	end

	// ==========
	// Clock is parked at the mode's idle level well before the select falls
	task automatic select(input logic mode3);
		idle_hi = mode3;
		sck = mode3;
		#40;
		cs_n = 1'b0;
		#HALF;
	endtask

	// Data set up while the clock is low, taken by the device on the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			#HALF;
			sck = 1'b1;
			rx[i] = so;
			#HALF;
		end
		if (!idle_hi)
			sck = 1'b0;
	endtask

	// Last rise must settle into the core before the select rises
	task automatic deselect();
		#HALF;
		cs_n = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule // sffp_host
`default_nettype wire

// ==== sffp_pkg.sv ====
`default_nettype none
package sffp_pkg;

	// ==========================================================
	// Opcodes of the 528-byte page group handled here
	localparam logic [7:0] OPC_BUF1_READ  = 8'hD1;
	localparam logic [7:0] OPC_PAGE_READ  = 8'hD2;
	localparam logic [7:0] OPC_BUF2_READ  = 8'hD3;
	localparam logic [7:0] OPC_BUF1_FAST  = 8'hD4;
	localparam logic [7:0] OPC_BUF2_FAST  = 8'hD6;
	localparam logic [7:0] OPC_STATUS     = 8'hD7;

	// ==========================================================
	// Frame layout
	localparam logic [2:0] DUMMY_PAGE_READ = 3'h4;
	localparam logic [2:0] DUMMY_BUF_FAST  = 3'h1;
	localparam logic [2:0] DUMMY_NONE      = 3'h0;
	localparam logic [1:0] ADDR_LAST_IDX   = 2'h2;
	localparam logic [2:0] BIT_LAST_IDX    = 3'h7;
	localparam int         PAGE_W          = 13;
	localparam int         BYTE_W          = 10;
	localparam int         PAGE_LSB        = 10;
	localparam int         PAGE_MSB        = 22;
	localparam int         BYTE_MSB        = 9;

	// ==========================================================
	// Reset values
	localparam logic MODE3_RESET = 1'h1;
	localparam logic CS_N_RESET  = 1'h1;

	// ==========================================================
	// Power-up timing
	localparam int CLK_MHZ                     = 200;
	localparam int SUPPLY_TO_SELECT_WAIT_US    = 85;
	localparam int PROGRAM_ERASE_POWERUP_DELAY_MS = 3;
	localparam int SUPPLY_TO_SELECT_WAIT_CYC   = SUPPLY_TO_SELECT_WAIT_US * CLK_MHZ;
	localparam int PE_DELAY_CYC = PROGRAM_ERASE_POWERUP_DELAY_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA} sffp_state_t;

	function automatic logic [2:0] dummy_count(input logic [7:0] opc);
		if (opc == OPC_PAGE_READ)
			return DUMMY_PAGE_READ;
		else if (opc == OPC_BUF1_FAST || opc == OPC_BUF2_FAST)
			return DUMMY_BUF_FAST;
		else
			return DUMMY_NONE;
	endfunction

	// Buffer-only opcodes carry page bits that are don't-care
	function automatic logic page_is_dummy(input logic [7:0] opc);
		return opc == OPC_BUF1_READ || opc == OPC_BUF2_READ
			|| opc == OPC_BUF1_FAST || opc == OPC_BUF2_FAST;
	endfunction

endpackage
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int PE_CYC = 50;
	logic        CLK, RESET, SCK, CS_N, SI, SO_OUT, SO_OE_N, MODE3, STANDBY;
	logic        PE_READY, OVERRUN, CMD_VALID, DATA_VALID, DATA_READY, TX_DRIVE, stall;
	logic [7:0]  CMD_OPCODE, DATA_OUT, TX_BYTE;
	logic [12:0] CMD_PAGE;
	logic [9:0]  CMD_BYTE;
	logic [7:0]  rx_q[$], exp_q[$];
	logic [31:0] cmd_q[$];
	logic [7:0]  opcs[6] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7};
	int          mismatches, checks, pe_cnt, seed;
	wire         so_wire;

	assign so_wire = (SO_OE_N === 1'b0) ? SO_OUT : 1'bz;
	always #2.5 CLK = ~CLK;

	sffp_front #(.PE_DELAY_CYC(PE_CYC)) dut (.CLK(CLK), .RESET(RESET), .SCK(SCK),
		.CS_N(CS_N), .SI(SI), .SO_OUT(SO_OUT), .SO_OE_N(SO_OE_N), .MODE3(MODE3),
		.STANDBY(STANDBY), .PE_READY(PE_READY), .OVERRUN(OVERRUN), .CMD_VALID(CMD_VALID),
		.CMD_OPCODE(CMD_OPCODE), .CMD_PAGE(CMD_PAGE), .CMD_BYTE(CMD_BYTE),
		.DATA_VALID(DATA_VALID), .DATA_OUT(DATA_OUT), .DATA_READY(DATA_READY),
		.TX_BYTE(TX_BYTE), .TX_DRIVE(TX_DRIVE));
	sffp_host host (.sck(SCK), .cs_n(CS_N), .si(SI), .so(so_wire));

	// ==========
	// Monitors and consumer
	always @(posedge CLK) begin
		if (CMD_VALID === 1'b1)
			cmd_q.push_back({CMD_OPCODE, CMD_PAGE, CMD_BYTE, MODE3});
		if (DATA_VALID === 1'b1 && DATA_READY === 1'b1)
			rx_q.push_back(DATA_OUT);
		#1;
		DATA_READY = stall ? 1'b0 : 1'($urandom % 2);
	end
	always @(negedge CLK)
		if (RESET === 1'b0 && PE_READY !== 1'b1)
			pe_cnt++;
	always @(SO_OUT)
		if (CS_N === 1'b0 && SO_OE_N === 1'b0)
			check(SCK, 1'b0, "output moved off a falling clock");

	// ==========
	// Checking and expectations
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s, seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	function automatic int n_dummy(input logic [7:0] opc);
		case (opc)
			8'hD2: return 4;
			8'hD4, 8'hD6: return 1;
			default: return 0;
		endcase
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Reserved bit set and dummies made unlike the payload, so slips show
	task automatic frame(input logic [7:0] opc, input logic mode3, input int n_pay);
		logic [12:0] page;
		logic [9:0]  bsel;
		logic [7:0]  r;
		logic [7:0]  pay[$];
		logic [23:0] addr;
		logic [31:0] c;
		page = 13'($urandom);
		bsel = 10'($urandom);
		addr = {1'b1, page, bsel};
		for (int i = 0; i < n_pay; i++)
			pay.push_back(8'($urandom));
		host.select(mode3);
		host.xfer(opc, r);
		check(SO_OE_N, 1'b1, "output driven unasked");
		if (opc != 8'hD7) begin
			for (int i = 2; i >= 0; i--)
				host.xfer(addr[i*8 +: 8], r);
			for (int i = 0; i < n_dummy(opc); i++)
				host.xfer(~pay[0], r);
		end
		foreach (pay[i]) begin
			host.xfer(pay[i], r);
			exp_q.push_back(pay[i]);
		end
		host.deselect();
		repeat (20) @(posedge CLK);
		check(cmd_q.size(), 1, "command count");
		if (cmd_q.size() == 1) begin
			c = cmd_q.pop_front();
			check(c[31:24], opc, "opcode");
			if (opc != 8'hD7) begin
				check(c[23:11], (opc == 8'hD2) ? page : 13'h0, "page");
				check(c[10:1], bsel, "byte address");
			end
			check(c[0], mode3, "clock mode");
		end
		check(rx_q.size(), exp_q.size(), "payload count");
		while (rx_q.size() > 0 && exp_q.size() > 0)
			check(rx_q.pop_front(), exp_q.pop_front(), "payload");
		rx_q.delete();
		exp_q.delete();
		cmd_q.delete();
	endtask

	// ==========
	// Main sequence
	initial begin : main
		logic [7:0]  r, tx, rot, first;
		logic [23:0] bits;
		logic        hit;
		CLK = 1'b0;
		RESET = 1'b1;
		DATA_READY = 1'b0;
		TX_BYTE = 8'h00;
		TX_DRIVE = 1'b0;
		stall = 1'b0;
		seed = $urandom(81860);
		repeat (3) @(posedge CLK);
		check(SO_OE_N, 1'b1, "output on in reset");
		check(MODE3, 1'b1, "mode in reset");
		check(STANDBY, 1'b0, "standby in reset");
		#1;
		RESET = 1'b0;
		repeat (2) @(posedge CLK);
		check(STANDBY, 1'b1, "standby after reset");
		repeat (17000) @(posedge CLK);
		check(pe_cnt, PE_CYC + 1, "program delay");
		for (int n = 0; n < 2; n++)
			foreach (opcs[i])
				frame(opcs[i], 1'($urandom % 2), 1 + ($urandom % 3));
		frame(8'hD2, 1'b0, 2);
		// Bytes during reset, then in the frame left open by it, are dropped
		host.select(1'b0);
		@(posedge CLK);
		#1;
		RESET = 1'b1;
		host.xfer(8'hD7, r);
		check(MODE3, 1'b1, "mode in mid reset");
		check(SO_OE_N, 1'b1, "output on in mid reset");
		@(posedge CLK);
		#1;
		RESET = 1'b0;
		for (int i = 0; i < 4; i++)
			host.xfer(i[0] ? 8'hD7 : 8'hD4, r);
		check(MODE3, 1'b1, "mode picked without a fresh fall");
		host.deselect();
		repeat (20) @(posedge CLK);
		check(cmd_q.size() + rx_q.size(), 0, "traffic before a fresh select");
		frame(8'hD6, 1'b1, 1);
		// Reply driven on the serial output
		tx = 8'($urandom);
		host.select(1'b1);
		host.xfer(8'hD7, r);
		@(posedge CLK);
		#1;
		TX_BYTE = tx;
		TX_DRIVE = 1'b1;
		host.xfer(8'h00, r);
		for (int i = 0; i < 3; i++) begin
			host.xfer(8'($urandom), r);
			bits = {bits[15:0], r};
		end
		check(SO_OE_N, 1'b0, "output not driving");
		hit = 1'b0;
		for (int k = 0; k < 8; k++) begin
			rot = (tx << k) | (tx >> (8 - k));
			hit = hit | (bits === {3{rot}});
		end
		check(hit, 1'b1, "reply bit order");
		host.deselect();
		check(SO_OE_N, 1'b1, "output on after release");
		@(posedge CLK);
		#1;
		TX_DRIVE = 1'b0;
		// Stalled consumer: buffer fills, later bytes dropped, oldest kept
		stall = 1'b1;
		first = 8'($urandom);
		host.select(1'b0);
		host.xfer(8'hD7, r);
		host.xfer(first, r);
		for (int i = 0; i < 5; i++)
			host.xfer(8'($urandom), r);
		check(OVERRUN, 1'b1, "overrun flag");
		host.deselect();
		rx_q.delete();
		stall = 1'b0;
		repeat (20) @(posedge CLK);
		check(rx_q.size() > 0 ? rx_q[0] : 9'h100, first, "oldest byte");
		host.select(1'b1);
		repeat (10) @(posedge CLK);
		check(OVERRUN, 1'b0, "overrun after select");
		host.deselect();
		report_and_stop();
	end

	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
